// ### pkg/tmr_map.svh
/*
 Register offsets, field positions and reset values of the timer control and flag block.
 Included by the package and by the timer module; holds definitions only.
*/
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH
// ----------------------------------------------------------------
// Register offsets (control B is fixed, the rest are local choices)
// ----------------------------------------------------------------
`define TMR_OFS_CTRL_A    8'h24
`define TMR_OFS_CTRL_B    8'h25
`define TMR_OFS_COUNT     8'h26
`define TMR_OFS_CMP_A     8'h27
`define TMR_OFS_CMP_B     8'h28
`define TMR_OFS_IRQ_MASK  8'h6E
`define TMR_OFS_IRQ_FLAGS 8'h35
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TMR_B_FOC_A       7
`define TMR_B_FOC_B       6
`define TMR_B_WGM_HI      3
`define TMR_B_CS_HI       2
`define TMR_A_COM_A_HI    7
`define TMR_A_COM_A_LO    6
`define TMR_A_COM_B_HI    5
`define TMR_A_COM_B_LO    4
`define TMR_A_WGM_HI      1
`define TMR_BIT_CMP_B     2
`define TMR_BIT_CMP_A     1
`define TMR_BIT_OVF       0
// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define TMR_RESET_BYTE    8'h00
`define TMR_MAX_VALUE     8'hFF
`define TMR_BOTTOM_VALUE  8'h00
`define TMR_CTRL_B_MASK   8'h0F
`define TMR_CTRL_A_MASK   8'hF3
`define TMR_IRQ_MASK_BITS 8'h07
`define TMR_PRESC_WIDTH   10
`define TMR_TAP_DIV8      3
`define TMR_TAP_DIV64     6
`define TMR_TAP_DIV256    8
`define TMR_TAP_DIV1K     10
`endif

// ### pkg/tmr_pkg.sv
/*
 Types of the timer control and flag block.
 Assumes tmr_map.svh is on the include path.
*/
package tmr_pkg;
`include "tmr_map.svh"
   typedef enum logic [2:0] {
      TMR_CS_STOP   = 3'h0,
      TMR_CS_DIV1   = 3'h1,
      TMR_CS_DIV8   = 3'h2,
      TMR_CS_DIV64  = 3'h3,
      TMR_CS_DIV256 = 3'h4,
      TMR_CS_DIV1K  = 3'h5,
      TMR_CS_EXT_FALL = 3'h6,
      TMR_CS_EXT_RISE = 3'h7
   } tmr_clk_sel_type;
   typedef enum logic [2:0] {
      TMR_WGM_NORMAL   = 3'h0,
      TMR_WGM_PC_FF    = 3'h1,
      TMR_WGM_CTC      = 3'h2,
      TMR_WGM_FAST_FF  = 3'h3,
      TMR_WGM_RSV4     = 3'h4,
      TMR_WGM_PC_OCRA  = 3'h5,
      TMR_WGM_RSV6     = 3'h6,
      TMR_WGM_FAST_OCRA = 3'h7
   } tmr_wave_mode_type;
   typedef enum logic [1:0] {
      TMR_COM_OFF    = 2'h0,
      TMR_COM_TOGGLE = 2'h1,
      TMR_COM_CLEAR  = 2'h2,
      TMR_COM_SET    = 2'h3
   } tmr_com_type;
endpackage

// ### verilog/tmr_timer0.sv
/*
 Control and flag part of an 8-bit timer/counter: clock source and prescaler, counter,
 two compare channels, force-compare strobes, interrupt mask and flags, and a
 minimal waveform output per channel. Assumes a CPU-style byte register port
 clocked by core_clk and a CPU that signals vector execution with one-cycle pulses.
*/
`timescale 1ns/1ns
`include "tmr_map.svh"
module tmr_timer0
   import tmr_pkg::*;
#(
   parameter int PRESC_WIDTH = `TMR_PRESC_WIDTH
)(
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       cpu_global_irq_enable,
   input  wire logic       vector_ack_overflow,
   input  wire logic       vector_ack_compare_a,
   input  wire logic       vector_ack_compare_b,
   input  wire logic       external_count_pin,
   output logic            irq_overflow,
   output logic            irq_compare_a,
   output logic            irq_compare_b,
   output logic            wave_out_a,
   output logic            wave_out_b,
   output logic            wave_out_a_enable,
   output logic            wave_out_b_enable
);
   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (PRESC_WIDTH < `TMR_PRESC_WIDTH) begin : g_bad_presc
      $error("PRESC_WIDTH too small for divide by 1024");
   end

   // ----------------------------------------------------------------
   // Registers and decode
   // ----------------------------------------------------------------
   logic [7:0]             control_a;
   logic                   waveform_mode_high_bit;
   logic [2:0]             clock_source_select;
   logic [7:0]             timer0_count_value;
   logic [7:0]             timer0_compare_a_value;
   logic [7:0]             timer0_compare_b_value;
   logic [2:0]             timer0_irq_mask;
   logic [2:0]             timer0_irq_flags;
   logic [PRESC_WIDTH-1:0] presc_count;
   logic                   pin_meta;
   logic                   pin_sync;
   logic                   pin_last;
   logic                   tick;
   logic                   block_match;
   logic                   count_down;
   logic                   force_compare_a;
   logic                   force_compare_b;
   logic                   match_a;
   logic                   match_b;
   logic                   overflow_event;
   logic                   is_pwm;
   logic [7:0]             top_value;
   logic [2:0]             next_flags;
   tmr_wave_mode_type      wave_mode;
   tmr_com_type            compare_out_mode_a;
   tmr_com_type            compare_out_mode_b;

   wire wr_ctrl_a = reg_write && (reg_addr == `TMR_OFS_CTRL_A);
   wire wr_ctrl_b = reg_write && (reg_addr == `TMR_OFS_CTRL_B);
   wire wr_count  = reg_write && (reg_addr == `TMR_OFS_COUNT);
   wire wr_cmp_a  = reg_write && (reg_addr == `TMR_OFS_CMP_A);
   wire wr_cmp_b  = reg_write && (reg_addr == `TMR_OFS_CMP_B);
   wire wr_mask   = reg_write && (reg_addr == `TMR_OFS_IRQ_MASK);
   wire wr_flags  = reg_write && (reg_addr == `TMR_OFS_IRQ_FLAGS);

   assign wave_mode = tmr_wave_mode_type'({waveform_mode_high_bit,
                                           control_a[`TMR_A_WGM_HI:0]});
   assign compare_out_mode_a =
      tmr_com_type'(control_a[`TMR_A_COM_A_HI:`TMR_A_COM_A_LO]);
   assign compare_out_mode_b =
      tmr_com_type'(control_a[`TMR_A_COM_B_HI:`TMR_A_COM_B_LO]);
   assign is_pwm = (wave_mode != TMR_WGM_NORMAL) && (wave_mode != TMR_WGM_CTC);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         control_a <= `TMR_RESET_BYTE;
      end else if (wr_ctrl_a) begin
         control_a <= reg_wdata & `TMR_CTRL_A_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         waveform_mode_high_bit <= 1'b0;
         clock_source_select    <= 3'h0;
      end else if (wr_ctrl_b) begin
         waveform_mode_high_bit <= reg_wdata[`TMR_B_WGM_HI];
         clock_source_select    <= reg_wdata[`TMR_B_CS_HI:0];
      end
   end

   // Strobes exist only for the write cycle, so nothing remains to read back
   assign force_compare_a = wr_ctrl_b && reg_wdata[`TMR_B_FOC_A] && !is_pwm;
   assign force_compare_b = wr_ctrl_b && reg_wdata[`TMR_B_FOC_B] && !is_pwm;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         timer0_compare_a_value <= `TMR_RESET_BYTE;
         timer0_compare_b_value <= `TMR_RESET_BYTE;
         timer0_irq_mask        <= 3'h0;
      end else begin
         if (wr_cmp_a) begin
            timer0_compare_a_value <= reg_wdata;
         end
         if (wr_cmp_b) begin
            timer0_compare_b_value <= reg_wdata;
         end
         if (wr_mask) begin
            timer0_irq_mask <= reg_wdata[`TMR_BIT_CMP_B:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock selection
   // ----------------------------------------------------------------
   // Pin is sampled regardless of its port direction, so software can drive it
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_last <= 1'b0;
      end else begin
         pin_meta <= external_count_pin;
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         presc_count <= '0;
      end else begin
         presc_count <= presc_count + 1'b1;
      end
   end

   always_comb begin
      unique case (tmr_clk_sel_type'(clock_source_select))
         TMR_CS_STOP:     tick = 1'b0;
         TMR_CS_DIV1:     tick = 1'b1;
         TMR_CS_DIV8:     tick = (presc_count[`TMR_TAP_DIV8-1:0] == '1);
         TMR_CS_DIV64:    tick = (presc_count[`TMR_TAP_DIV64-1:0] == '1);
         TMR_CS_DIV256:   tick = (presc_count[`TMR_TAP_DIV256-1:0] == '1);
         TMR_CS_DIV1K:    tick = (presc_count[`TMR_TAP_DIV1K-1:0] == '1);
         TMR_CS_EXT_FALL: tick = pin_last && !pin_sync;
         TMR_CS_EXT_RISE: tick = !pin_last && pin_sync;
      endcase
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   always_comb begin
      unique case (wave_mode)
         TMR_WGM_CTC, TMR_WGM_PC_OCRA, TMR_WGM_FAST_OCRA: top_value = timer0_compare_a_value;
         default: top_value = `TMR_MAX_VALUE;
      endcase
   end

   // Compare happens on the tick against the value held in that cycle
   assign match_a = tick && !block_match
                    && (timer0_count_value == timer0_compare_a_value);
   assign match_b = tick && !block_match
                    && (timer0_count_value == timer0_compare_b_value);

   always_comb begin
      unique case (wave_mode)
         TMR_WGM_PC_FF, TMR_WGM_PC_OCRA:
            overflow_event = tick && count_down
                             && (timer0_count_value == `TMR_BOTTOM_VALUE + 8'h01);
         TMR_WGM_FAST_OCRA:
            overflow_event = tick && (timer0_count_value == top_value);
         default:
            overflow_event = tick && (timer0_count_value == `TMR_MAX_VALUE);
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         timer0_count_value <= `TMR_RESET_BYTE;
         count_down         <= 1'b0;
      end else if (wr_count) begin
         timer0_count_value <= reg_wdata;
      end else if (tick) begin
         unique case (wave_mode)
            TMR_WGM_PC_FF, TMR_WGM_PC_OCRA: begin
               if (!count_down && timer0_count_value >= top_value) begin
                  count_down         <= 1'b1;
                  timer0_count_value <= timer0_count_value - 8'h01;
               end else if (count_down && timer0_count_value == `TMR_BOTTOM_VALUE) begin
                  count_down         <= 1'b0;
                  timer0_count_value <= timer0_count_value + 8'h01;
               end else if (count_down) begin
                  timer0_count_value <= timer0_count_value - 8'h01;
               end else begin
                  timer0_count_value <= timer0_count_value + 8'h01;
               end
            end
            TMR_WGM_CTC, TMR_WGM_FAST_FF, TMR_WGM_FAST_OCRA: begin
               // Only a real match clears in CLEAR_ON_MATCH_MODE; a forced strobe never reaches here
               count_down <= 1'b0;
               if (timer0_count_value == top_value) begin
                  timer0_count_value <= `TMR_BOTTOM_VALUE;
               end else begin
                  timer0_count_value <= timer0_count_value + 8'h01;
               end
            end
            default: begin
               count_down         <= 1'b0;
               timer0_count_value <= timer0_count_value + 8'h01;
            end
         endcase
      end
   end

   // Block covers the first tick after a counter write, however late it comes
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         block_match <= 1'b0;
      end else if (wr_count) begin
         block_match <= 1'b1;
      end else if (tick) begin
         block_match <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Flags and requests
   // ----------------------------------------------------------------
   always_comb begin
      next_flags = timer0_irq_flags;
      if (wr_flags) begin
         next_flags = next_flags & ~reg_wdata[`TMR_BIT_CMP_B:0];
      end
      if (vector_ack_overflow) begin
         next_flags[`TMR_BIT_OVF] = 1'b0;
      end
      if (vector_ack_compare_a) begin
         next_flags[`TMR_BIT_CMP_A] = 1'b0;
      end
      if (vector_ack_compare_b) begin
         next_flags[`TMR_BIT_CMP_B] = 1'b0;
      end
      // Hardware set wins over any clear in the same cycle; forced strobes never set
      if (overflow_event) begin
         next_flags[`TMR_BIT_OVF] = 1'b1;
      end
      if (match_a) begin
         next_flags[`TMR_BIT_CMP_A] = 1'b1;
      end
      if (match_b) begin
         next_flags[`TMR_BIT_CMP_B] = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         timer0_irq_flags <= 3'h0;
      end else begin
         timer0_irq_flags <= next_flags;
      end
   end

   assign irq_overflow  = cpu_global_irq_enable && timer0_irq_mask[`TMR_BIT_OVF]
                          && timer0_irq_flags[`TMR_BIT_OVF];
   assign irq_compare_a = cpu_global_irq_enable && timer0_irq_mask[`TMR_BIT_CMP_A]
                          && timer0_irq_flags[`TMR_BIT_CMP_A];
   assign irq_compare_b = cpu_global_irq_enable && timer0_irq_mask[`TMR_BIT_CMP_B]
                          && timer0_irq_flags[`TMR_BIT_CMP_B];

   // ----------------------------------------------------------------
   // Waveform outputs (non-PWM actions only)
   // ----------------------------------------------------------------
   // No PWM waveform shaping is done in this block; here PWM modes hold
   function automatic logic wave_next(input logic cur, input tmr_com_type mode);
      unique case (mode)
         TMR_COM_OFF:    wave_next = cur;
         TMR_COM_TOGGLE: wave_next = !cur;
         TMR_COM_CLEAR:  wave_next = 1'b0;
         TMR_COM_SET:    wave_next = 1'b1;
      endcase
   endfunction

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wave_out_a <= 1'b0;
         wave_out_b <= 1'b0;
      end else if (!is_pwm) begin
         if (match_a || force_compare_a) begin
            wave_out_a <= wave_next(wave_out_a, compare_out_mode_a);
         end
         if (match_b || force_compare_b) begin
            wave_out_b <= wave_next(wave_out_b, compare_out_mode_b);
         end
      end
   end

   assign wave_out_a_enable = (compare_out_mode_a != TMR_COM_OFF);
   assign wave_out_b_enable = (compare_out_mode_b != TMR_COM_OFF);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= `TMR_RESET_BYTE;
      end else if (reg_read) begin
         unique case (reg_addr)
            `TMR_OFS_CTRL_A:    reg_rdata <= control_a;
            `TMR_OFS_CTRL_B:    reg_rdata <= {4'h0, waveform_mode_high_bit,
                                              clock_source_select};
            `TMR_OFS_COUNT:     reg_rdata <= timer0_count_value;
            `TMR_OFS_CMP_A:     reg_rdata <= timer0_compare_a_value;
            `TMR_OFS_CMP_B:     reg_rdata <= timer0_compare_b_value;
            `TMR_OFS_IRQ_MASK:  reg_rdata <= {5'h00, timer0_irq_mask};
            `TMR_OFS_IRQ_FLAGS: reg_rdata <= {5'h00, timer0_irq_flags};
            default:            reg_rdata <= `TMR_RESET_BYTE;
         endcase
      end
   end

endmodule // tmr_timer0

// ### testbench/tmr_timer0_assertions.sv
/* Port-level checks of the timer control and flag block.
   Bound to tmr_timer0 from the bench top; tmr_map.svh is on the include path. */
`timescale 1ns/1ns
`include "tmr_map.svh"
module tmr_timer0_assertions
   import tmr_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       nrst,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       cpu_global_irq_enable,
   input wire logic       vector_ack_compare_b,
   input wire logic       irq_overflow,
   input wire logic       irq_compare_a,
   input wire logic       irq_compare_b,
   input wire logic       wave_out_a,
   input wire logic       wave_out_a_enable,
   input wire logic       wave_out_b_enable
);
   // ----------------------------------------------------------------
   // Mode shadow
   // ----------------------------------------------------------------
   logic [7:0] ctrl_a_seen;
   logic       force_np;
   logic       force_pw;
   // Rebuilt from bus writes, since the design's own copy is not at the ports
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_a_seen <= `TMR_RESET_BYTE;
      end else if (reg_write && reg_addr == `TMR_OFS_CTRL_A) begin
         ctrl_a_seen <= reg_wdata;
      end
   end
   assign force_np = reg_write && reg_addr == `TMR_OFS_CTRL_B && reg_wdata[`TMR_B_FOC_A]
                     && !ctrl_a_seen[0] && !reg_wdata[`TMR_B_WGM_HI];
   // Reserved modes 4 and 6 are left out: their output behaviour is a local choice
   assign force_pw = reg_write && reg_addr == `TMR_OFS_CTRL_B && reg_wdata[`TMR_B_FOC_A]
                     && ctrl_a_seen[0];
   default clocking chk_clk @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   chk_force_set: assert property (
      force_np && ctrl_a_seen[7:6] == 2'h3 |=> wave_out_a)
      else $error("forced set left output A low");
   chk_force_clear: assert property (
      force_np && ctrl_a_seen[7:6] == 2'h2 |=> !wave_out_a)
      else $error("forced clear left output A high");
   chk_force_toggle: assert property (
      force_np && ctrl_a_seen[7:6] == 2'h1 |=> wave_out_a != $past(wave_out_a))
      else $error("forced toggle did not flip output A");
   chk_pwm_force_ignored: assert property (
      force_pw |=> $stable(wave_out_a))
      else $error("force acted in a PWM mode");
   chk_enable_a_mode: assert property (
      reg_write && reg_addr == `TMR_OFS_CTRL_A
      |=> wave_out_a_enable == (($past(reg_wdata) & 8'hC0) != 8'h00))
      else $error("output A enable does not follow its mode");
   chk_enable_b_mode: assert property (
      reg_write && reg_addr == `TMR_OFS_CTRL_A
      |=> wave_out_b_enable == (($past(reg_wdata) & 8'h30) != 8'h00))
      else $error("output B enable does not follow its mode");
   chk_ctrl_b_read: assert property (
      reg_read && reg_addr == `TMR_OFS_CTRL_B |=> reg_rdata[7:4] == 4'h0)
      else $error("control B upper bits read nonzero");
   chk_reserved_read: assert property (
      reg_read && (reg_addr == `TMR_OFS_IRQ_MASK || reg_addr == `TMR_OFS_IRQ_FLAGS)
      |=> reg_rdata[7:3] == 5'h00)
      else $error("mask or flag reserved bits read nonzero");
   chk_irq_global: assert property (
      !cpu_global_irq_enable |-> !(irq_overflow || irq_compare_a || irq_compare_b))
      else $error("interrupt requested with global enable low");
   // Assumes no compare B match lands in the acknowledge cycle
   chk_ack_clears: assert property (
      vector_ack_compare_b |=> !irq_compare_b)
      else $error("vector acknowledge left compare B request up");
   cov_force: cover property (force_np);
   cov_irq_b: cover property (irq_compare_b);
   cov_ack_b: cover property (vector_ack_compare_b && irq_compare_b);
endmodule // tmr_timer0_assertions

// ### testbench/test_tmr_timer0.sv
/* Directed bench of the timer control and flag block: bus tasks, scenarios, verdict.
   Assumes tmr_pkg, tmr_map.svh and tmr_timer0_assertions are compiled before it. */
`timescale 1ns/1ns
`include "tmr_map.svh"
module test_tmr_timer0
   import tmr_pkg::*;
();
   localparam logic [7:0] CA  = `TMR_OFS_CTRL_A;
   localparam logic [7:0] CB  = `TMR_OFS_CTRL_B;
   localparam logic [7:0] CNT = `TMR_OFS_COUNT;
   localparam logic [7:0] CMA = `TMR_OFS_CMP_A;
   localparam logic [7:0] CMB = `TMR_OFS_CMP_B;
   localparam logic [7:0] MSK = `TMR_OFS_IRQ_MASK;
   localparam logic [7:0] FLG = `TMR_OFS_IRQ_FLAGS;
   localparam int         LIMIT = 20000;
   logic       core_clk, nrst, reg_write, reg_read, glb, ext_pin;
   logic       irq_overflow, irq_compare_a, irq_compare_b;
   logic       wave_out_a, wave_out_b, wave_out_a_enable, wave_out_b_enable;
   logic [2:0] ack_vec;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   logic [1:0] coms [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
   logic       wants [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   int         divs [5] = '{1, 8, 64, 256, 1024};
   int         bad_count = 0;
   int         tests_run = 0;
   int         cycles = 0;
   int         i;
   wire  [7:0] irqs = {5'h00, irq_compare_b, irq_compare_a, irq_overflow};
   wire  [7:0] waves = {4'h0, wave_out_a_enable, wave_out_b_enable, wave_out_a, wave_out_b};

   tmr_timer0 #(.PRESC_WIDTH(10)) dut_u (
      .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_write(reg_write),
      .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .cpu_global_irq_enable(glb), .vector_ack_overflow(ack_vec[0]),
      .vector_ack_compare_a(ack_vec[1]), .vector_ack_compare_b(ack_vec[2]),
      .external_count_pin(ext_pin), .irq_overflow(irq_overflow),
      .irq_compare_a(irq_compare_a), .irq_compare_b(irq_compare_b),
      .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
      .wave_out_a_enable(wave_out_a_enable), .wave_out_b_enable(wave_out_b_enable));

   always #20 core_clk = ~core_clk;
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      tests_run++;
      if (seen !== want) begin
         bad_count++;
         $display("ERROR %0t: got %h expected %h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      @(posedge core_clk);
      #1 d = reg_rdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] want);
      logic [7:0] d;
      rd(a, d);
      check(d, want);
   endtask
   // Starts the counter with the given source, then stops it again
   task automatic run(input logic [7:0] cs, input int n);
      wr(CB, cs);
      repeat (n) @(posedge core_clk);
      wr(CB, 8'h00);
   endtask
   task automatic ack(input logic [2:0] m);
      @(posedge core_clk);
      ack_vec <= m;
      @(posedge core_clk);
      ack_vec <= 3'h0;
      #1;
   endtask
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         $display("ERROR %0t: timeout", $time);
         conclude();
      end
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      nrst = 1'b0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      glb = 1'b0;
      ack_vec = 3'h0;
      ext_pin = 1'b0;
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      rc(CB, 8'h00);
      rc(FLG, 8'h00);
      wr(CB, 8'hF8);
      rc(CB, 8'h08);
      wr(CB, 8'h00);
      wr(MSK, 8'hFF);
      rc(MSK, 8'h07);
      wr(CNT, 8'hA5);
      rc(CNT, 8'hA5);
      wr(CMA, 8'h30);
      wr(CMB, 8'h34);
      wr(CNT, 8'h2E);
      run(8'h01, 20);
      rc(FLG, 8'h06);
      @(posedge core_clk);
      glb <= 1'b1;
      @(posedge core_clk);
      #1 check(irqs, 8'h06);
      wr(MSK, 8'h04);
      check(irqs, 8'h04);
      @(posedge core_clk);
      glb <= 1'b0;
      @(posedge core_clk);
      #1 check(irqs, 8'h00);
      @(posedge core_clk);
      glb <= 1'b1;
      wr(FLG, 8'h00);
      rc(FLG, 8'h06);
      ack(3'h2);
      rc(FLG, 8'h04);
      ack(3'h4);
      rc(FLG, 8'h00);
      wr(CNT, 8'hFD);
      run(8'h01, 10);
      rc(FLG, 8'h01);
      wr(MSK, 8'h01);
      check(irqs, 8'h01);
      wr(FLG, 8'h01);
      rc(FLG, 8'h00);
      wr(CNT, 8'h30);
      run(8'h01, 0);
      rc(FLG, 8'h00);
      for (i = 0; i < 5; i++) begin
         wr(CNT, 8'h00);
         run(8'(i + 1), 4 * divs[i]);
         rd(CNT, v);
         check({7'h00, v >= 8'h04 && v <= 8'h06}, 8'h01);
      end
      for (i = 6; i < 8; i++) begin
         wr(CNT, 8'h00);
         wr(CB, 8'(i));
         repeat (3) begin
            @(posedge core_clk);
            ext_pin <= 1'b1;
            repeat (4) @(posedge core_clk);
            ext_pin <= 1'b0;
            repeat (4) @(posedge core_clk);
         end
         wr(CB, 8'h00);
         rc(CNT, 8'h03);
      end
      for (i = 0; i < 4; i++) begin
         wr(CA, {coms[i], coms[i], 4'h0});
         wr(CB, 8'hC0);
         check(waves, {6'h03, wants[i], wants[i]});
      end
      rc(FLG, 8'h00);
      wr(CNT, 8'h30);
      wr(CA, 8'h52);
      wr(CB, 8'hC0);
      check(waves, 8'h0F);
      rc(CNT, 8'h30);
      rc(FLG, 8'h00);
      wr(CA, 8'h53);
      wr(CB, 8'hC0);
      check(waves, 8'h0F);
      wr(CB, 8'h00);
      wr(CA, 8'h00);
      check(waves & 8'h0C, 8'h00);
      // Clear on match: 2E, 2F, 30 then wraps to 00 and climbs to 03
      wr(CA, 8'h02);
      wr(CNT, 8'h2E);
      run(8'h01, 4);
      rc(CNT, 8'h03);
      rc(FLG, 8'h02);
      // Phase correct: FE up to FF, down to 00 (overflow), back up to 02
      wr(FLG, 8'h07);
      wr(CA, 8'h01);
      wr(CNT, 8'hFE);
      run(8'h01, 256);
      rc(FLG, 8'h07);
      rc(CNT, 8'h02);
      conclude();
   end
endmodule // test_tmr_timer0

bind tmr_timer0 tmr_timer0_assertions chk_u (
   .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_write(reg_write),
   .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .cpu_global_irq_enable(cpu_global_irq_enable),
   .vector_ack_compare_b(vector_ack_compare_b), .irq_overflow(irq_overflow),
   .irq_compare_a(irq_compare_a), .irq_compare_b(irq_compare_b),
   .wave_out_a(wave_out_a), .wave_out_a_enable(wave_out_a_enable),
   .wave_out_b_enable(wave_out_b_enable));
